// ### hw/cbf_regs.sv
// Backoff seed, exponent and automatic-acknowledge filter registers with
// the random backoff generator and the acknowledge decision for one frame.
// Assumes an AXI4-Lite master, frame header fields decoded upstream and
// presented for one cycle with frameValid, all inputs synchronous to clk.
`include "cbf_defines.svh"

module cbf_regs (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// AXI4-Lite write channels
	input wire logic awvalid,
	output logic awready,
	input wire cbf_pkg::cbf_addr_t awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire cbf_pkg::cbf_word_t wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI4-Lite read channels
	input wire logic arvalid,
	output logic arready,
	input wire cbf_pkg::cbf_addr_t araddr,
	output logic rvalid,
	input wire logic rready,
	output cbf_pkg::cbf_word_t rdata,
	output logic [1:0] rresp,
	// Power and backoff requests
	input wire logic deepSleepWake,
	input wire logic backoffReq,
	input wire cbf_pkg::cbf_exp_t backoffExp,
	output logic backoffValid,
	output cbf_pkg::cbf_count_t backoffCount,
	// Received frame header summary
	input wire logic autoAckRxMode,
	input wire logic frameValid,
	input wire logic [2:0] frameType,
	input wire logic [1:0] frameVersion,
	input wire logic ackRequest,
	input wire logic securityEnabled,
	input wire logic dataRequestCmd,
	input wire logic srcAddrOnly,
	input wire logic [15:0] srcPanId,
	input wire logic [15:0] ownPanId,
	// Filter and acknowledge decision
	output logic decisionValid,
	output logic frameAccept,
	output logic ackSend,
	output logic ackFramePending,
	output logic [1:0] ackFrameVersion,
	// Current settings
	output cbf_pkg::cbf_seed_t backoffSeed,
	output cbf_pkg::cbf_exp_t lowerBackoffExp,
	output cbf_pkg::cbf_exp_t upperBackoffExp
);
	import cbf_pkg::*;

	// ==========================================
	// Helper functions

	// Maps a byte address to a register select, bit 3 flags unmapped
	function automatic logic [3:0] decodeAddr(input cbf_addr_t addr);
		logic [3:0] sel;
		sel = 4'h8;
		if (addr == `CBF_ADDR_SEED_LOW) begin
			sel = 4'h1;
		end else if (addr == `CBF_ADDR_ACK_CTRL) begin
			sel = 4'h2;
		end else if (addr == `CBF_ADDR_EXPONENTS) begin
			sel = 4'h4;
		end
		return sel;
	endfunction

	// Mask of 2^exp - 1, saturating at eight bits
	function automatic cbf_count_t expMask(input cbf_exp_t e);
		cbf_count_t m;
		m = 8'hFF;
		if (e < `CBF_MAX_EXP) begin
			m = 8'((9'h001 << e) - 9'h001);
		end
		return m;
	endfunction

	// ==========================================
	// Register storage
	logic [7:0] seedLow_q;
	logic [2:0] seedHigh_q;
	logic [1:0] verLimit_q;
	logic pendBit_q;
	logic suppress_q;
	logic coordFlag_q;
	cbf_exp_t upperExp_q;
	cbf_exp_t lowerExp_q;

	// ==========================================
	// Write path: address and data taken in either order
	logic awHeld_q;
	logic wHeld_q;
	cbf_addr_t awAddr_q;
	logic [7:0] wByte_q;
	logic wLane_q;
	logic doWrite;
	logic [3:0] wSel;

	assign doWrite = awHeld_q && wHeld_q && !bvalid;
	assign wSel = decodeAddr(awAddr_q);

	// Capture write address
	always_ff @(posedge clk) begin
		if (rst) begin
			awHeld_q <= 1'b0;
			awAddr_q <= '0;
			awready <= 1'b0;
		end else begin
			awready <= !awHeld_q && !(awvalid && awready) && !bvalid;
			if (awvalid && awready) begin
				awHeld_q <= 1'b1;
				awAddr_q <= awaddr;
			end else if (doWrite) begin
				awHeld_q <= 1'b0;
			end
		end
	end

	// Capture write data, only byte lane 0 carries register bits
	always_ff @(posedge clk) begin
		if (rst) begin
			wHeld_q <= 1'b0;
			wByte_q <= '0;
			wLane_q <= 1'b0;
			wready <= 1'b0;
		end else begin
			wready <= !wHeld_q && !(wvalid && wready) && !bvalid;
			if (wvalid && wready) begin
				wHeld_q <= 1'b1;
				wByte_q <= wdata[7:0];
				wLane_q <= wstrb[0];
			end else if (doWrite) begin
				wHeld_q <= 1'b0;
			end
		end
	end

	// Write response once both halves are in
	always_ff @(posedge clk) begin
		if (rst) begin
			bvalid <= 1'b0;
			bresp <= `CBF_RESP_OKAY;
		end else if (doWrite) begin
			bvalid <= 1'b1;
			bresp <= wSel[3] ? `CBF_RESP_SLVERR : `CBF_RESP_OKAY;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// Register updates
	always_ff @(posedge clk) begin
		if (rst) begin
			seedLow_q <= `CBF_RST_SEED_LOW;
			seedHigh_q <= `CBF_RST_SEED_HIGH;
			verLimit_q <= `CBF_RST_VER_LIMIT;
			pendBit_q <= 1'b0;
			suppress_q <= 1'b0;
			coordFlag_q <= 1'b0;
			upperExp_q <= `CBF_RST_UPPER_EXP;
			lowerExp_q <= `CBF_RST_LOWER_EXP;
		end else if (doWrite && wLane_q) begin
			if (wSel[0]) begin
				seedLow_q <= wByte_q;
			end
			if (wSel[1]) begin
				verLimit_q <= wByte_q[`CBF_VER_MSB:`CBF_VER_LSB];
				pendBit_q <= wByte_q[`CBF_PEND_BIT];
				suppress_q <= wByte_q[`CBF_SUPP_BIT];
				coordFlag_q <= wByte_q[`CBF_COORD_BIT];
				seedHigh_q <= wByte_q[`CBF_SEEDHI_MSB:0];
			end
			if (wSel[2]) begin
				upperExp_q <= wByte_q[`CBF_UPPER_MSB:`CBF_UPPER_LSB];
				lowerExp_q <= wByte_q[`CBF_LOWER_MSB:0];
			end
		end
	end

	// ==========================================
	// Read path: one cycle from address to data
	logic [3:0] rSel;
	logic [7:0] rByte;

	assign rSel = decodeAddr(araddr);

	// Select the read byte
	always_comb begin
		rByte = 8'h00;
		if (rSel[0]) begin
			rByte = seedLow_q;
		end else if (rSel[1]) begin
			rByte = {verLimit_q, pendBit_q, suppress_q, coordFlag_q, seedHigh_q};
		end else if (rSel[2]) begin
			rByte = {upperExp_q, lowerExp_q};
		end
	end

	// Read handshake and data
	always_ff @(posedge clk) begin
		if (rst) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= `CBF_RESP_OKAY;
		end else begin
			arready <= !rvalid && !(arvalid && arready);
			if (arvalid && arready) begin
				rvalid <= 1'b1;
				rdata <= {24'h000000, rByte};
				rresp <= rSel[3] ? `CBF_RESP_SLVERR : `CBF_RESP_OKAY;
			end else if (rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	// ==========================================
	// Random backoff generator
	cbf_seed_t lfsr_q;
	cbf_seed_t lfsr_d;
	cbf_seed_t seedNow;
	cbf_bo_state_t boState_q;
	cbf_exp_t drawExp_q;
	cbf_exp_t clampExp;

	assign seedNow = {seedHigh_q, seedLow_q};
	assign lfsr_d = {lfsr_q[9:0], lfsr_q[10] ^ lfsr_q[8]};
	assign clampExp = (backoffExp > upperExp_q) ? upperExp_q : backoffExp;

	// Shift every cycle, reload from the seed after deepest sleep wakeup
	always_ff @(posedge clk) begin
		if (rst) begin
			lfsr_q <= {`CBF_RST_SEED_HIGH, `CBF_RST_SEED_LOW};
		end else if (deepSleepWake) begin
			lfsr_q <= (seedNow == '0) ? 11'h001 : seedNow;
		end else begin
			lfsr_q <= lfsr_d;
		end
	end

	// Draw sequencing: latch exponent, then present one count
	always_ff @(posedge clk) begin
		if (rst) begin
			boState_q <= CBF_BO_IDLE;
			drawExp_q <= '0;
			backoffValid <= 1'b0;
			backoffCount <= '0;
		end else begin
			backoffValid <= 1'b0;
			case (boState_q)
				CBF_BO_IDLE: begin
					if (backoffReq && !deepSleepWake) begin
						drawExp_q <= clampExp;
						boState_q <= CBF_BO_DRAW;
					end
				end
				CBF_BO_DRAW: begin
					backoffValid <= 1'b1;
					if (upperExp_q == '0 && lowerExp_q == '0) begin
						backoffCount <= '0;
					end else begin
						backoffCount <= lfsr_q[7:0] & expMask(drawExp_q);
					end
					boState_q <= CBF_BO_DONE;
				end
				CBF_BO_DONE: begin
					boState_q <= CBF_BO_IDLE;
				end
				default: begin
					boState_q <= CBF_BO_IDLE;
				end
			endcase
		end
	end

	// ==========================================
	// Frame filter and acknowledge decision
	logic versionOk;
	logic coordOk;
	logic dataOrCmd;
	logic pendCopy;

	assign versionOk = (verLimit_q == 2'h3) || (frameVersion <= verLimit_q);
	assign dataOrCmd = (frameType == `CBF_FT_DATA) || (frameType == `CBF_FT_CMD);
	assign coordOk = !(coordFlag_q && srcAddrOnly && dataOrCmd) || (srcPanId == ownPanId);
	assign pendCopy = dataRequestCmd || (verLimit_q[1] && frameType == `CBF_FT_CMD
		&& frameVersion[1] && securityEnabled);

	// One decision per received frame while autoAckRxMode is set
	always_ff @(posedge clk) begin
		if (rst) begin
			decisionValid <= 1'b0;
			frameAccept <= 1'b0;
			ackSend <= 1'b0;
			ackFramePending <= 1'b0;
			ackFrameVersion <= 2'h0;
		end else begin
			decisionValid <= frameValid && autoAckRxMode;
			ackFrameVersion <= 2'h0;
			if (frameValid && autoAckRxMode) begin
				frameAccept <= versionOk && coordOk;
				ackSend <= versionOk && coordOk && ackRequest && !suppress_q;
				ackFramePending <= pendCopy && pendBit_q;
			end
		end
	end

	// ==========================================
	// Settings outputs
	always_ff @(posedge clk) begin
		if (rst) begin
			backoffSeed <= {`CBF_RST_SEED_HIGH, `CBF_RST_SEED_LOW};
			lowerBackoffExp <= `CBF_RST_LOWER_EXP;
			upperBackoffExp <= `CBF_RST_UPPER_EXP;
		end else begin
			backoffSeed <= seedNow;
			lowerBackoffExp <= lowerExp_q;
			upperBackoffExp <= upperExp_q;
		end
	end

	// ==========================================
	// Checks
	default clocking cbfClk @(posedge clk); endclocking
	default disable iff (rst);

	sequence frameSeen;
		frameValid && autoAckRxMode;
	endsequence

	sequence drawStart;
		backoffReq && !deepSleepWake && boState_q == CBF_BO_IDLE;
	endsequence

	chk_seed_concat: assert property (##1 backoffSeed == $past(seedNow))
		else $error("seed output does not follow seed registers");

	chk_wake_reload: assert property (deepSleepWake && seedNow != '0 |=> lfsr_q == $past(seedNow))
		else $error("generator not reloaded from seed on wakeup");

	chk_version_reject: assert property (frameSeen ##0 (frameVersion > verLimit_q && verLimit_q != 2'h3)
		|=> !frameAccept && !ackSend)
		else $error("frame above version limit passed");

	chk_ack_version: assert property (decisionValid |-> ackFrameVersion == 2'h0)
		else $error("ack frame version not zero");

	chk_pending_copy: assert property (frameSeen ##0 dataRequestCmd |=> ackFramePending == $past(pendBit_q))
		else $error("pending bit not copied into ack");

	chk_suppress_ack: assert property (frameSeen ##0 suppress_q |=> !ackSend)
		else $error("ack sent while suppressed");

	chk_coord_filter: assert property (frameSeen ##0 (coordFlag_q && srcAddrOnly && dataOrCmd
		&& srcPanId != ownPanId) |=> !frameAccept)
		else $error("foreign source PAN accepted by coordinator");

	chk_zero_backoff: assert property (drawStart ##0 (upperExp_q == '0 && lowerExp_q == '0)
		##1 (upperExp_q == '0 && lowerExp_q == '0) |=> backoffValid && backoffCount == '0)
		else $error("nonzero backoff with both exponents zero");

	chk_backoff_range: assert property (drawStart |-> ##2 backoffValid
		&& backoffCount <= expMask($past(clampExp, 2)))
		else $error("backoff count out of range");

	chk_write_answer: assert property (doWrite |=> bvalid)
		else $error("write not answered");
endmodule

// ### shared/cbf_defines.svh
// Constants for the backoff seed, acknowledge filter and exponent registers.
// Assumes a 32-bit AXI4-Lite register bus and one 50 MHz clock domain.
`ifndef CBF_DEFINES_SVH
`define CBF_DEFINES_SVH

// ==========================================
// Register indices and byte addresses
`define CBF_IDX_SEED_LOW 8'h2D
`define CBF_IDX_ACK_CTRL 8'h2E
`define CBF_IDX_EXPONENTS 8'h2F
`define CBF_ADDR_W 10
`define CBF_ADDR_SEED_LOW 10'h0B4
`define CBF_ADDR_ACK_CTRL 10'h0B8
`define CBF_ADDR_EXPONENTS 10'h0BC

// ==========================================
// Field positions
`define CBF_VER_MSB 7
`define CBF_VER_LSB 6
`define CBF_PEND_BIT 5
`define CBF_SUPP_BIT 4
`define CBF_COORD_BIT 3
`define CBF_SEEDHI_MSB 2
`define CBF_UPPER_MSB 7
`define CBF_UPPER_LSB 4
`define CBF_LOWER_MSB 3

// ==========================================
// Reset values and exponent limit
`define CBF_RST_SEED_LOW 8'hEA
`define CBF_RST_SEED_HIGH 3'h2
`define CBF_RST_VER_LIMIT 2'h1
`define CBF_RST_UPPER_EXP 4'h5
`define CBF_RST_LOWER_EXP 4'h3
`define CBF_MAX_EXP 4'h8

// ==========================================
// Frame types and bus answers
`define CBF_FT_DATA 3'h1
`define CBF_FT_CMD 3'h3
`define CBF_RESP_OKAY 2'h0
`define CBF_RESP_SLVERR 2'h2

`endif

// ### shared/cbf_pkg.sv
// Types shared by the backoff and acknowledge configuration block.
// Assumes the constants header is on the include path.
package cbf_pkg;
	// ==========================================
	// Bus sizes and backoff generator state
	typedef logic [31:0] cbf_word_t;
	typedef logic [9:0] cbf_addr_t;
	typedef logic [10:0] cbf_seed_t;
	typedef logic [3:0] cbf_exp_t;
	typedef logic [7:0] cbf_count_t;
	typedef enum logic [2:0] {
		CBF_BO_IDLE = 3'h1,
		CBF_BO_DRAW = 3'h2,
		CBF_BO_DONE = 3'h4
	} cbf_bo_state_t;
endpackage

// ### test/test_csma_backoff_ack_filter_cfg.sv
// Self-checking bench for the backoff seed, exponent and acknowledge filter registers.
// Assumes cbf_pkg and cbf_defines.svh are compiled ahead and one 50 MHz clock.
`include "cbf_defines.svh"

module test_csma_backoff_ack_filter_cfg;
	timeunit 1ns;
	timeprecision 1ps;
	import cbf_pkg::*;

	// ==========================================
	// Signals
	logic clk = 0, rst = 1;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	cbf_addr_t awaddr = '0, araddr = '0;
	cbf_word_t wdata = '0;
	logic [3:0] wstrb = '0;
	logic awready, wready, bvalid, arready, rvalid, backoffValid, decisionValid;
	logic [1:0] bresp, rresp, ackFrameVersion;
	cbf_word_t rdata;
	logic deepSleepWake = 0, backoffReq = 0, autoAckRxMode = 1, frameValid = 0;
	cbf_exp_t backoffExp = '0;
	cbf_count_t backoffCount, c1, c2;
	logic [2:0] frameType = '0;
	logic [1:0] frameVersion = '0;
	logic ackRequest = 0, securityEnabled = 0, dataRequestCmd = 0, srcAddrOnly = 0;
	logic [15:0] srcPanId = '0, ownPanId = 16'h1234;
	logic frameAccept, ackSend, ackFramePending;
	cbf_seed_t backoffSeed;
	cbf_exp_t lowerBackoffExp, upperBackoffExp;
	int n_mismatch = 0, n_compared = 0;

	cbf_regs u_dut (.clk(clk), .rst(rst), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
		.bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
		.rready(rready), .rdata(rdata), .rresp(rresp), .deepSleepWake(deepSleepWake),
		.backoffReq(backoffReq), .backoffExp(backoffExp), .backoffValid(backoffValid),
		.backoffCount(backoffCount), .autoAckRxMode(autoAckRxMode), .frameValid(frameValid),
		.frameType(frameType), .frameVersion(frameVersion), .ackRequest(ackRequest),
		.securityEnabled(securityEnabled), .dataRequestCmd(dataRequestCmd), .srcAddrOnly(srcAddrOnly),
		.srcPanId(srcPanId), .ownPanId(ownPanId), .decisionValid(decisionValid), .frameAccept(frameAccept),
		.ackSend(ackSend), .ackFramePending(ackFramePending), .ackFrameVersion(ackFrameVersion),
		.backoffSeed(backoffSeed), .lowerBackoffExp(lowerBackoffExp), .upperBackoffExp(upperBackoffExp));

	// ==========================================
	// Clock
	initial begin
		forever #10 clk = ~clk;
	end

	// ==========================================
	// Shared tasks
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask

	task automatic print_verdict();
		$display("compared %0d, mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Write one byte; both halves offered together, released as each is taken
	task automatic wr(input cbf_addr_t a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] er);
		logic aT, wT, aD, wD, bT;
		logic [1:0] resp;
		int n;
		aD = 0;
		wD = 0;
		bT = 0;
		n = 0;
		@(posedge clk);
		awvalid <= 1;
		awaddr <= a;
		wvalid <= 1;
		wdata <= {24'h000000, d};
		wstrb <= s;
		bready <= 1;
		while (!(aD && wD && bT) && n < 100) begin
			#1;
			aT = awvalid & awready;
			wT = wvalid & wready;
			bT = bvalid;
			resp = bresp;
			@(posedge clk);
			if (aT) begin
				awvalid <= 0;
				aD = 1;
			end
			if (wT) begin
				wvalid <= 0;
				wD = 1;
			end
			n++;
		end
		bready <= 0;
		check(bT, 1'b1, "write answer");
		check(resp, er, "write response");
	endtask

	// Read one word and compare data and response
	task automatic rd(input cbf_addr_t a, input logic [31:0] ed, input logic [1:0] er);
		logic aT, rT;
		cbf_word_t d;
		logic [1:0] resp;
		int n;
		rT = 0;
		n = 0;
		@(posedge clk);
		arvalid <= 1;
		araddr <= a;
		rready <= 1;
		while (!rT && n < 100) begin
			#1;
			aT = arvalid & arready;
			rT = rvalid;
			d = rdata;
			resp = rresp;
			@(posedge clk);
			if (aT)
				arvalid <= 0;
			n++;
		end
		rready <= 0;
		check(rT, 1'b1, "read answer");
		check(d, ed, "read data");
		check(resp, er, "read response");
	endtask

	// One header pulse; ex holds accept, ack and pending expected
	task automatic frame(input logic [2:0] ft, input logic [1:0] v, input logic [3:0] f,
			input logic [15:0] pan, input logic [2:0] ex);
		@(posedge clk);
		frameValid <= 1;
		frameType <= ft;
		frameVersion <= v;
		{ackRequest, securityEnabled, dataRequestCmd, srcAddrOnly} <= f;
		srcPanId <= pan;
		@(posedge clk);
		frameValid <= 0;
		#1;
		check(decisionValid, 1'b1, "decision");
		check({frameAccept, ackSend, ackFramePending}, ex, "decision flags");
		check(ackFrameVersion, 2'h0, "ack version");
	endtask

	// One backoff draw with a bounded wait for the answer
	task automatic draw(input cbf_exp_t e, output cbf_count_t c);
		int n;
		@(posedge clk);
		backoffReq <= 1;
		backoffExp <= e;
		@(posedge clk);
		backoffReq <= 0;
		#1;
		for (n = 0; n < 8 && backoffValid !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		check(backoffValid, 1'b1, "backoff answer");
		c = backoffCount;
	endtask

	task automatic wake();
		@(posedge clk);
		deepSleepWake <= 1;
		@(posedge clk);
		deepSleepWake <= 0;
		repeat (3) @(posedge clk);
	endtask

	// ==========================================
	// Watchdog
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		print_verdict();
	end

	// ==========================================
	// Main sequence
	initial begin
		repeat (20) @(posedge clk);
		rst <= 0;
		#1;
		check({backoffSeed, lowerBackoffExp, upperBackoffExp}, {11'h2EA, 4'h3, 4'h5}, "reset copies");
		rd(`CBF_ADDR_SEED_LOW, 32'h000000EA, `CBF_RESP_OKAY);
		rd(`CBF_ADDR_ACK_CTRL, 32'h00000042, `CBF_RESP_OKAY);
		rd(`CBF_ADDR_EXPONENTS, 32'h00000053, `CBF_RESP_OKAY);
		rd(10'h0C0, 32'h00000000, `CBF_RESP_SLVERR);
		wr(10'h000, 8'h77, 4'hF, `CBF_RESP_SLVERR);
		wr(`CBF_ADDR_SEED_LOW, 8'h11, 4'h0, `CBF_RESP_OKAY);
		rd(`CBF_ADDR_SEED_LOW, 32'h000000EA, `CBF_RESP_OKAY);
		// Seed assembly from both registers
		wr(`CBF_ADDR_SEED_LOW, 8'h5C, 4'h1, `CBF_RESP_OKAY);
		wr(`CBF_ADDR_ACK_CTRL, 8'h45, 4'h1, `CBF_RESP_OKAY);
		repeat (2) @(posedge clk);
		#1;
		check(backoffSeed, 11'h55C, "seed");
		rd(`CBF_ADDR_ACK_CTRL, 32'h00000045, `CBF_RESP_OKAY);
		// Version limit against every frame version
		for (int l = 0; l < 4; l++) begin
			wr(`CBF_ADDR_ACK_CTRL, {l[1:0], 6'h02}, 4'h1, `CBF_RESP_OKAY);
			for (int v = 0; v < 4; v++)
				frame(`CBF_FT_DATA, v[1:0], 4'h8, 16'h1234, {3{l == 3 || v <= l}} & 3'h6);
		end
		// Pending bit copies
		wr(`CBF_ADDR_ACK_CTRL, 8'hA2, 4'h1, `CBF_RESP_OKAY);
		frame(`CBF_FT_CMD, 2'h0, 4'hA, 16'h1234, 3'h7);
		frame(`CBF_FT_CMD, 2'h2, 4'hC, 16'h1234, 3'h7);
		frame(`CBF_FT_DATA, 2'h2, 4'hC, 16'h1234, 3'h6);
		wr(`CBF_ADDR_ACK_CTRL, 8'h62, 4'h1, `CBF_RESP_OKAY);
		frame(`CBF_FT_CMD, 2'h1, 4'hC, 16'h1234, 3'h6);
		wr(`CBF_ADDR_ACK_CTRL, 8'hC2, 4'h1, `CBF_RESP_OKAY);
		frame(`CBF_FT_CMD, 2'h0, 4'hA, 16'h1234, 3'h6);
		// Suppress and coordinator filtering
		wr(`CBF_ADDR_ACK_CTRL, 8'h52, 4'h1, `CBF_RESP_OKAY);
		frame(`CBF_FT_DATA, 2'h0, 4'h8, 16'h1234, 3'h4);
		frame(`CBF_FT_DATA, 2'h0, 4'h9, 16'h4321, 3'h4);
		wr(`CBF_ADDR_ACK_CTRL, 8'h4A, 4'h1, `CBF_RESP_OKAY);
		frame(`CBF_FT_DATA, 2'h0, 4'h9, 16'h1234, 3'h6);
		frame(`CBF_FT_DATA, 2'h0, 4'h9, 16'h4321, 3'h0);
		frame(`CBF_FT_CMD, 2'h0, 4'h9, 16'h4321, 3'h0);
		frame(`CBF_FT_DATA, 2'h0, 4'h8, 16'h4321, 3'h6);
		// No decision outside auto-ack mode
		@(posedge clk);
		autoAckRxMode <= 0;
		frameValid <= 1;
		@(posedge clk);
		frameValid <= 0;
		autoAckRxMode <= 1;
		#1;
		check(decisionValid, 1'b0, "decision outside mode");
		// Backoff counts and exponent bounds
		wr(`CBF_ADDR_EXPONENTS, 8'h00, 4'h1, `CBF_RESP_OKAY);
		draw(4'h3, c1);
		check(c1, 8'h00, "zero exponents");
		wr(`CBF_ADDR_EXPONENTS, 8'h32, 4'h1, `CBF_RESP_OKAY);
		repeat (4) begin
			draw(4'h8, c1);
			check(c1 & 8'hF8, 8'h00, "clamped count");
			draw(4'h2, c1);
			check(c1 & 8'hFC, 8'h00, "count range");
		end
		wr(`CBF_ADDR_EXPONENTS, 8'h80, 4'h1, `CBF_RESP_OKAY);
		rd(`CBF_ADDR_EXPONENTS, 32'h00000080, `CBF_RESP_OKAY);
		check({lowerBackoffExp, upperBackoffExp}, {4'h0, 4'h8}, "exponent copies");
		// Wakeup reload repeats the same draw
		wake();
		draw(4'h8, c1);
		wr(`CBF_ADDR_SEED_LOW, 8'h5C, 4'h1, `CBF_RESP_OKAY);
		wake();
		draw(4'h8, c2);
		check(c2, c1, "reload after wakeup");
		print_verdict();
	end
endmodule
